// ---- irqpl_defs.svh ----
`ifndef IRQPL_DEFS_SVH
`define IRQPL_DEFS_SVH

// ==========================================
// register offsets (module level, word index)
`define IRQPL_ADDR_W 5
`define IRQPL_OFS_SEL0 5'h00
`define IRQPL_OFS_SEL1 5'h01
`define IRQPL_OFS_SEL2 5'h02
`define IRQPL_OFS_SEL3 5'h03

// ==========================================
// reset value and writable masks (reserved bits are zero)
`define IRQPL_RST_VAL 16'h0000
`define IRQPL_MASK_SEL0 16'hF3FF
`define IRQPL_MASK_SEL1 16'hC03F
`define IRQPL_MASK_SEL2 16'hC3FF
`define IRQPL_MASK_SEL3 16'hC03F

// ==========================================
// field positions (low bit of each two-bit field)
`define IRQPL_POS_PLL 14
`define IRQPL_POS_LOW_VOLTAGE 12
`define IRQPL_POS_DBG_RX_FULL 8
`define IRQPL_POS_DBG_TX_EMPTY 6
`define IRQPL_POS_DBG_TRACE 4
`define IRQPL_POS_DBG_BREAKPOINT 2
`define IRQPL_POS_DBG_STEP_COUNT 0
`define IRQPL_POS_PORT_D 14
`define IRQPL_POS_FLASH_BUFS_EMPTY 4
`define IRQPL_POS_FLASH_CMD_DONE 2
`define IRQPL_POS_FLASH_FAULT 0
`define IRQPL_POS_ASER0_TX_EMPTY 14
`define IRQPL_POS_SSER0_TX_EMPTY 8
`define IRQPL_POS_SSER0_RX_FULL 6
`define IRQPL_POS_PORT_A 4
`define IRQPL_POS_PORT_B 2
`define IRQPL_POS_PORT_C 0
`define IRQPL_POS_TWI_FAULT 14
`define IRQPL_POS_ASER0_RX_FULL 4
`define IRQPL_POS_ASER0_RX_FAULT 2
`define IRQPL_POS_ASER0_TX_IDLE 0

// ==========================================
// field codes
`define IRQPL_CODE_OFF 2'h0
`define IRQPL_CODE_A 2'h1
`define IRQPL_CODE_B 2'h2
`define IRQPL_CODE_C 2'h3

// ==========================================
// source counts
`define IRQPL_NUM_SRC 21
`define IRQPL_NUM_UPPER 7
`define IRQPL_NUM_LEVELS 4
`define IRQPL_SRC_W 5

`endif

// ---- irqpl_pkg.sv ----
package irqpl_pkg;

   typedef logic [1:0] irqpl_field_t;
   typedef logic [15:0] irqpl_word_t;
   typedef logic [3:0] irqpl_lvl_onehot_t;

   typedef enum logic [1:0]
   {
      IRQPL_RANGE_LOWER = 2'h1,
      IRQPL_RANGE_UPPER = 2'h2
   } irqpl_range_t;

endpackage

// ---- irqpl_lvl_enc.sv ----
`timescale 1ns/1ps
`default_nettype none

module irqpl_lvl_enc
#(
   parameter int N = 21,
   parameter int W = 5
)
(
   // requests of one level
   input wire logic [N-1:0] i_req,
   // lowest active source
   output logic o_valid,
   output logic [W-1:0] o_index
);

   // ==========================================
   // lowest-numbered request wins
   always_comb
   begin
      o_valid = 1'b0;
      o_index = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (i_req[i])
         begin
            o_valid = 1'b1;
            o_index = W'(i); // see R14
         end
      end
   end

endmodule

`default_nettype wire

// ---- irqpl_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irqpl_defs.svh"

// Summary of operation
// R1: upper-range field: 00 off, 01 level 1, 10 level 2, 11 level 3.
// R2: lower-range field: 00 off, 01 level 0, 10 level 1, 11 level 2.
// R3: every priority field resets to 00, so every source starts disabled.
// R4: software writes zero into reserved bit positions.
// R5: first register bits 15-14 hold the clock synthesizer level, upper range.
// R6: first register bits 13-12 hold the low-voltage level, upper range.
// R7: first register debug fields at 9-8, 7-6, 5-4, 3-2, 1-0, upper range.
// R8: reserved bits 11-10, 13-6 and 13-10 of registers one to three read zero.
// R9: second register bits 15-14 hold port D level, lower range.
// R10: second register flash fields at 5-4, 3-2, 1-0, lower range.
// R11: third register bits 15-14 hold async serial 0 transmit-empty level.
// R12: third register sync serial 0 fields at 9-8 and 7-6, lower range.
// R13: third register ports A, B, C at 5-4, 3-2, 1-0, lower range.
// R14: within a level the lowest source number wins.
// R15: register address is system base plus module offset.
// R16: disabled sources never reach encoder, core or wake-up.
// R17: writes take effect next cycle; reads return fields, reserved as zero.
module irqpl_top
(
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // register port (module offset)
   input wire logic [`IRQPL_ADDR_W-1:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [15:0] I_REG_WDATA,
   output logic [15:0] O_REG_RDATA,
   // peripheral requests
   input wire logic [`IRQPL_NUM_SRC-1:0] I_IRQ_REQ,
   // per-level result
   output logic [`IRQPL_NUM_LEVELS-1:0] O_LEVEL_ACTIVE,
   output logic [`IRQPL_SRC_W-1:0] O_LVL0_SRC,
   output logic [`IRQPL_SRC_W-1:0] O_LVL1_SRC,
   output logic [`IRQPL_SRC_W-1:0] O_LVL2_SRC,
   output logic [`IRQPL_SRC_W-1:0] O_LVL3_SRC,
   // wake-up to system integration
   output logic O_WAKE_REQ
);

   localparam int NSRC = `IRQPL_NUM_SRC;
   localparam int NLVL = `IRQPL_NUM_LEVELS;
   localparam int SW = `IRQPL_SRC_W;

   // ==========================================
   // field decode
   function automatic irqpl_pkg::irqpl_lvl_onehot_t decode_level
   (
      input irqpl_pkg::irqpl_field_t fld,
      input irqpl_pkg::irqpl_range_t rng
   );
      irqpl_pkg::irqpl_lvl_onehot_t res;
      res = 4'h0;
      if (rng == irqpl_pkg::IRQPL_RANGE_UPPER)
      begin
         unique case (fld)
            `IRQPL_CODE_OFF: res = 4'h0; // see R16
            `IRQPL_CODE_A: res = 4'h2; // see R1
            `IRQPL_CODE_B: res = 4'h4; // see R1
            `IRQPL_CODE_C: res = 4'h8; // see R1
         endcase
      end
      else
      begin
         unique case (fld)
            `IRQPL_CODE_OFF: res = 4'h0; // see R16
            `IRQPL_CODE_A: res = 4'h1; // see R2
            `IRQPL_CODE_B: res = 4'h2; // see R2
            `IRQPL_CODE_C: res = 4'h4; // see R2
         endcase
      end
      return res;
   endfunction

   function automatic irqpl_pkg::irqpl_field_t pick
   (
      input irqpl_pkg::irqpl_word_t word,
      input int pos
   );
      return word[pos +: 2];
   endfunction

   // ==========================================
   // register state
   irqpl_pkg::irqpl_word_t sel0_reg;
   irqpl_pkg::irqpl_word_t sel0_next;
   irqpl_pkg::irqpl_word_t sel1_reg;
   irqpl_pkg::irqpl_word_t sel1_next;
   irqpl_pkg::irqpl_word_t sel2_reg;
   irqpl_pkg::irqpl_word_t sel2_next;
   irqpl_pkg::irqpl_word_t sel3_reg;
   irqpl_pkg::irqpl_word_t sel3_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;

   // the system base is decoded upstream; only the module offset arrives here
   always_comb
   begin
      sel0_next = sel0_reg;
      sel1_next = sel1_reg;
      sel2_next = sel2_reg;
      sel3_next = sel3_reg;
      rdata_next = rdata_reg;
      if (I_REG_WR)
      begin
         unique case (I_REG_ADDR) // see R15
            `IRQPL_OFS_SEL0: sel0_next = I_REG_WDATA & `IRQPL_MASK_SEL0; // see R17
            `IRQPL_OFS_SEL1: sel1_next = I_REG_WDATA & `IRQPL_MASK_SEL1; // see R17
            `IRQPL_OFS_SEL2: sel2_next = I_REG_WDATA & `IRQPL_MASK_SEL2; // see R17
            `IRQPL_OFS_SEL3: sel3_next = I_REG_WDATA & `IRQPL_MASK_SEL3; // see R17
            default: ;
         endcase
      end
      if (I_REG_RD)
      begin
         // reserved bits are never stored, so they read back as zero
         unique case (I_REG_ADDR)
            `IRQPL_OFS_SEL0: rdata_next = sel0_reg; // see R8
            `IRQPL_OFS_SEL1: rdata_next = sel1_reg; // see R8
            `IRQPL_OFS_SEL2: rdata_next = sel2_reg; // see R8
            `IRQPL_OFS_SEL3: rdata_next = sel3_reg;
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         sel0_reg <= `IRQPL_RST_VAL; // see R3
         sel1_reg <= `IRQPL_RST_VAL; // see R3
         sel2_reg <= `IRQPL_RST_VAL; // see R3
         sel3_reg <= `IRQPL_RST_VAL; // see R3
         rdata_reg <= 16'h0000;
      end
      else
      begin
         sel0_reg <= sel0_next;
         sel1_reg <= sel1_next;
         sel2_reg <= sel2_next;
         sel3_reg <= sel3_next;
         rdata_reg <= rdata_next;
      end
   end

   assign O_REG_RDATA = rdata_reg;

   // ==========================================
   // per-source fields, in source-number order
   irqpl_pkg::irqpl_field_t fld [NSRC];

   always_comb
   begin
      fld[0] = pick(sel0_reg, `IRQPL_POS_PLL); // see R5
      fld[1] = pick(sel0_reg, `IRQPL_POS_LOW_VOLTAGE); // see R6
      fld[2] = pick(sel0_reg, `IRQPL_POS_DBG_RX_FULL); // see R7
      fld[3] = pick(sel0_reg, `IRQPL_POS_DBG_TX_EMPTY); // see R7
      fld[4] = pick(sel0_reg, `IRQPL_POS_DBG_TRACE); // see R7
      fld[5] = pick(sel0_reg, `IRQPL_POS_DBG_BREAKPOINT); // see R7
      fld[6] = pick(sel0_reg, `IRQPL_POS_DBG_STEP_COUNT); // see R7
      fld[7] = pick(sel1_reg, `IRQPL_POS_PORT_D); // see R9
      fld[8] = pick(sel1_reg, `IRQPL_POS_FLASH_BUFS_EMPTY); // see R10
      fld[9] = pick(sel1_reg, `IRQPL_POS_FLASH_CMD_DONE); // see R10
      fld[10] = pick(sel1_reg, `IRQPL_POS_FLASH_FAULT); // see R10
      fld[11] = pick(sel2_reg, `IRQPL_POS_ASER0_TX_EMPTY); // see R11
      fld[12] = pick(sel2_reg, `IRQPL_POS_SSER0_TX_EMPTY); // see R12
      fld[13] = pick(sel2_reg, `IRQPL_POS_SSER0_RX_FULL); // see R12
      fld[14] = pick(sel2_reg, `IRQPL_POS_PORT_A); // see R13
      fld[15] = pick(sel2_reg, `IRQPL_POS_PORT_B); // see R13
      fld[16] = pick(sel2_reg, `IRQPL_POS_PORT_C); // see R13
      fld[17] = pick(sel3_reg, `IRQPL_POS_TWI_FAULT);
      fld[18] = pick(sel3_reg, `IRQPL_POS_ASER0_RX_FULL);
      fld[19] = pick(sel3_reg, `IRQPL_POS_ASER0_RX_FAULT);
      fld[20] = pick(sel3_reg, `IRQPL_POS_ASER0_TX_IDLE);
   end

   // ==========================================
   // route each active request onto its level
   logic [NSRC-1:0] lvl_req [NLVL];

   always_comb
   begin
      irqpl_pkg::irqpl_lvl_onehot_t oh;
      oh = 4'h0;
      for (int l = 0; l < NLVL; l++)
      begin
         lvl_req[l] = '0;
      end
      for (int s = 0; s < NSRC; s++)
      begin
         oh = decode_level(fld[s], (s < `IRQPL_NUM_UPPER) ?
                           irqpl_pkg::IRQPL_RANGE_UPPER : irqpl_pkg::IRQPL_RANGE_LOWER);
         for (int l = 0; l < NLVL; l++)
         begin
            lvl_req[l][s] = I_IRQ_REQ[s] & oh[l]; // see R16
         end
      end
   end

   logic [NLVL-1:0] enc_valid;
   logic [SW-1:0] enc_index [NLVL];

   for (genvar g = 0; g < NLVL; g++)
   begin : g_enc
      irqpl_lvl_enc #(.N(NSRC), .W(SW)) u_enc
      (
         .i_req(lvl_req[g]),
         .o_valid(enc_valid[g]),
         .o_index(enc_index[g])
      );
   end

   // ==========================================
   // registered results
   logic [NLVL-1:0] active_reg;
   logic [NLVL-1:0] active_next;
   logic [SW-1:0] src_reg [NLVL];
   logic [SW-1:0] src_next [NLVL];
   logic wake_reg;
   logic wake_next;

   always_comb
   begin
      active_next = enc_valid; // see R14
      for (int l = 0; l < NLVL; l++)
      begin
         src_next[l] = enc_index[l]; // see R14
      end
      wake_next = |enc_valid; // see R16
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST)
   begin
      if (I_RST)
      begin
         active_reg <= '0;
         for (int l = 0; l < NLVL; l++)
         begin
            src_reg[l] <= '0;
         end
         wake_reg <= 1'b0;
      end
      else
      begin
         active_reg <= active_next;
         for (int l = 0; l < NLVL; l++)
         begin
            src_reg[l] <= src_next[l];
         end
         wake_reg <= wake_next;
      end
   end

   assign O_LEVEL_ACTIVE = active_reg;
   assign O_LVL0_SRC = src_reg[0];
   assign O_LVL1_SRC = src_reg[1];
   assign O_LVL2_SRC = src_reg[2];
   assign O_LVL3_SRC = src_reg[3];
   assign O_WAKE_REQ = wake_reg;

endmodule

`default_nettype wire

// ---- irqpl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irqpl_defs.svh"
module irqpl_chk
(
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // register port
   input wire logic [`IRQPL_ADDR_W-1:0] I_REG_ADDR,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   input wire logic [15:0] I_REG_WDATA,
   input wire logic [15:0] O_REG_RDATA,
   // requests and results
   input wire logic [`IRQPL_NUM_SRC-1:0] I_IRQ_REQ,
   input wire logic [`IRQPL_NUM_LEVELS-1:0] O_LEVEL_ACTIVE,
   input wire logic [`IRQPL_SRC_W-1:0] O_LVL0_SRC,
   input wire logic [`IRQPL_SRC_W-1:0] O_LVL1_SRC,
   input wire logic [`IRQPL_SRC_W-1:0] O_LVL2_SRC,
   input wire logic [`IRQPL_SRC_W-1:0] O_LVL3_SRC,
   input wire logic O_WAKE_REQ
);
   default clocking @(posedge I_CLK_SYS); endclocking
   default disable iff (I_RST);
   logic [`IRQPL_NUM_SRC-1:0] req_reg;
   function automatic logic [15:0] msk(input logic [4:0] a);
      case (a)
         5'h00: return `IRQPL_MASK_SEL0;
         5'h01: return `IRQPL_MASK_SEL1;
         5'h02: return `IRQPL_MASK_SEL2;
         5'h03: return `IRQPL_MASK_SEL3;
         default: return 16'h0000;
      endcase
   endfunction
   // =====
   // requests seen by the winner stage
   always_ff @(posedge I_CLK_SYS or posedge I_RST)
      if (I_RST) req_reg <= '0;
      else req_reg <= I_IRQ_REQ;
   a_reset_clear: assert property ($fell(I_RST) |->
      O_REG_RDATA == 16'h0000 && O_LEVEL_ACTIVE == 4'h0)
      else $error("outputs not clear after reset");
   a_wake_any: assert property (O_WAKE_REQ == (|O_LEVEL_ACTIVE))
      else $error("wake differs from level activity");
   a_idle_quiet: assert property (I_IRQ_REQ == '0 |=>
      O_LEVEL_ACTIVE == 4'h0 && !O_WAKE_REQ)
      else $error("activity without request");
   a_upper_not_zero: assert property (O_LEVEL_ACTIVE[0] |-> O_LVL0_SRC >= 5'h07)
      else $error("upper source at level 0");
   a_lower_not_three: assert property (O_LEVEL_ACTIVE[3] |-> O_LVL3_SRC < 5'h07)
      else $error("lower source at level 3");
   a_winner_requested: assert property (O_LEVEL_ACTIVE[1] |-> req_reg[O_LVL1_SRC])
      else $error("level 1 winner not requesting");
   a_empty_src_zero: assert property (!O_LEVEL_ACTIVE[2] |-> O_LVL2_SRC == 5'h00)
      else $error("idle level 2 index not zero");
   a_reserved_zero: assert property (I_REG_RD |=>
      (O_REG_RDATA & ~msk($past(I_REG_ADDR))) == 16'h0000)
      else $error("reserved bits read nonzero");
   a_rdata_holds: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
      else $error("read data moved without read");
   a_write_readback: assert property (I_REG_WR && !I_REG_RD ##1
      I_REG_RD && !I_REG_WR && $stable(I_REG_ADDR) |=>
      O_REG_RDATA == (msk($past(I_REG_ADDR, 2)) & $past(I_REG_WDATA, 2)))
      else $error("read after write mismatch");
   c_unmapped: cover property (I_REG_RD && I_REG_ADDR > 5'h03);
   c_level3: cover property (O_LEVEL_ACTIVE[3]);
   c_wake: cover property (O_WAKE_REQ);
endmodule
bind irqpl_top irqpl_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_REG_ADDR(I_REG_ADDR),
   .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
   .I_IRQ_REQ(I_IRQ_REQ), .O_LEVEL_ACTIVE(O_LEVEL_ACTIVE), .O_LVL0_SRC(O_LVL0_SRC),
   .O_LVL1_SRC(O_LVL1_SRC), .O_LVL2_SRC(O_LVL2_SRC), .O_LVL3_SRC(O_LVL3_SRC), .O_WAKE_REQ(O_WAKE_REQ));
`default_nettype wire

// ---- irqpl_bus_bfm.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irqpl_defs.svh"
module irqpl_bus_bfm
(
   // clock
   input wire logic i_clk,
   // register port drive
   output logic [4:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [15:0] o_wdata
);
   initial
   begin
      o_addr = 5'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 16'h0000;
   end
   function automatic logic [15:0] msk(input logic [4:0] a);
      case (a)
         5'h00: return `IRQPL_MASK_SEL0;
         5'h01: return `IRQPL_MASK_SEL1;
         5'h02: return `IRQPL_MASK_SEL2;
         5'h03: return `IRQPL_MASK_SEL3;
         default: return 16'h0000;
      endcase
   endfunction
   // =====
   // tasks start at a falling edge; the strobe stays up for the next call
   task automatic wr(input logic [4:0] a, input logic [15:0] d, input bit obey);
      o_addr = a;
      o_wdata = obey ? (d & msk(a)) : d;
      o_rd = 1'b0;
      o_wr = 1'b1;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [4:0] a);
      o_addr = a;
      o_wr = 1'b0;
      o_rd = 1'b1;
      @(negedge i_clk);
   endtask
   // released lines show a changed value, never the last one
   task automatic idle();
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
      @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// ---- irq_priority_level_config_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "irqpl_defs.svh"
module irq_priority_level_config_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [20:0] req = '0;
   logic lv_on = 1'b0;
   logic [4:0] addr;
   logic wr;
   logic rd;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [3:0] act;
   logic [4:0] s0, s1, s2, s3;
   logic wake;
   bit m_rd, m_lv;
   int err_total = 0;
   int check_count = 0;
   int cyc = 0;
   irqpl_pkg::irqpl_word_t sh [4];
   irqpl_pkg::irqpl_word_t q_rd [$];
   logic [24:0] q_lv [$];
   localparam int RG [21] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
   localparam int LB [21] = '{14, 12, 8, 6, 4, 2, 0, 14, 4, 2, 0, 14, 8, 6, 4, 2, 0, 14, 4, 2, 0};
   always #2.5 clk = ~clk;
   irqpl_bus_bfm bus (.i_clk(clk), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
   irqpl_top dut (.I_CLK_SYS(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd),
      .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_IRQ_REQ(req), .O_LEVEL_ACTIVE(act),
      .O_LVL0_SRC(s0), .O_LVL1_SRC(s1), .O_LVL2_SRC(s2), .O_LVL3_SRC(s3), .O_WAKE_REQ(wake));
   // =====
   // reference of the level outputs
   function automatic logic [24:0] model(input logic [20:0] r);
      logic [3:0] a;
      logic [4:0] s [4];
      logic [1:0] f;
      int l;
      a = 4'h0;
      s = '{default: 5'h00};
      for (int i = 0; i < 21; i++)
      begin
         f = sh[RG[i]][LB[i] +: 2];
         l = (i < 7) ? int'(f) : int'(f) - 1;
         if (r[i] && f != 2'h0 && !a[l])
         begin
            a[l] = 1'b1;
            s[l] = i[4:0];
         end
      end
      return {|a, s[3], s[2], s[1], s[0], a};
   endfunction
   task automatic results();
      $display("errors=%0d checks=%0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp_rd(input irqpl_pkg::irqpl_word_t e, input irqpl_pkg::irqpl_word_t g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic cmp_lv(input logic [24:0] e, input logic [24:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("Error t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic w(input logic [4:0] a, input logic [15:0] d, input bit obey);
      if (a < 5'h04) sh[a[1:0]] = d & bus.msk(a);
      bus.wr(a, d, obey);
   endtask
   task automatic r(input logic [4:0] a);
      q_rd.push_back(a < 5'h04 ? sh[a[1:0]] : 16'h0000);
      bus.rd(a);
   endtask
   task automatic lv(input logic [20:0] v);
      req = v;
      q_lv.push_back(model(v));
      lv_on = 1'b1;
      @(negedge clk);
   endtask
   task automatic rest();
      lv_on = 1'b0;
      bus.idle();
   endtask
   task automatic do_reset();
      rst = 1'b1;
      sh = '{default: 16'h0000};
      repeat (5) @(negedge clk);
      rst = 1'b0;
   endtask
   // =====
   // result monitor and hang guard
   always @(posedge clk)
   begin
      cyc++;
      m_rd = rd && !rst;
      m_lv = lv_on;
      #1;
      if (m_rd) cmp_rd(q_rd.pop_front(), rdata);
      if (m_lv) cmp_lv(q_lv.pop_front(), {wake, s3, s2, s1, s0, act});
      if (cyc == 5000)
      begin
         err_total++;
         results();
      end
   end
   initial
   begin
      do_reset();
      void'($urandom(56));
      for (int a = 0; a < 5; a++) r(a[4:0]);
      r(5'h1F);
      rest();
      lv('1);
      rest();
      for (int a = 0; a < 5; a++) w(a[4:0], 16'hFFFF, 1'b0);
      for (int a = 0; a < 5; a++) r(a[4:0]);
      w(5'h02, 16'h1234, 1'b0);
      r(5'h02);
      rest();
      for (int c = 1; c < 4; c++)
      begin
         for (int a = 0; a < 4; a++) w(a[4:0], {8{c[1:0]}}, 1'b1);
         rest();
         lv('1);
         for (int s = 0; s < 21; s++) lv(21'h1 << s);
         rest();
      end
      repeat (40)
      begin
         for (int a = 0; a < 4; a++) w(a[4:0], 16'($urandom), 1'b1);
         rest();
         repeat (4) lv(21'($urandom));
         rest();
      end
      do_reset();
      for (int a = 0; a < 4; a++) r(a[4:0]);
      rest();
      results();
   end
endmodule
`default_nettype wire
